//--- rtl/tsr_regs.vh
// How it works
// RULE1: Each transfer opens with START, then a 7-bit address and a direction bit.
// RULE2: When addressed as receiver, the device acknowledges every received byte; the code leaves a pointer byte with bits 3-0 above 9 unacknowledged.
// RULE3: The master ends every access with STOP.
// RULE4: No auto-increment; each access touches only the selected register.
// RULE5: The pointer is kept, so later reads return the same register.
// RULE6: SDA falling with SCL high is START, rising with SCL high is STOP.
// RULE7: START or STOP inside a byte releases SDA and drops the transfer.
// RULE8: Slave address is 0011 followed by the three address-select pin levels.
// RULE9: Address byte acknowledged only on a match; otherwise stay off the bus.
// RULE10: Address byte bit 0 is direction: 1 read, 0 write.
// RULE11: The master gives a ninth clock after each byte for the acknowledge.
// RULE12: After the master's NAK on a read, the device keeps SDA released.
// RULE13: SCL stuck low or high for the timeout resets the serial interface.
// RULE14: Ambient temperature is read-only, loaded whole after each conversion period.
// RULE15: Alert drives when temperature leaves the upper/lower window; limits are read-write.
// RULE16: An 8-bit write-only pointer byte selects registers; it resets to zero.
// RULE17: The master writes zeros to pointer bits 7-4; bits 3-0 select.
// RULE18: Pointer 0..9 maps capability through resolution in documented order.
// RULE19: Pointer bytes beyond the ten registers are not acknowledged.
// RULE20: Only the master starts transfers and picks transmit or receive.
// RULE21: With timeout range zero the bus timeout lies between 10 and 60 ms.
// RULE22: SCL and SDA are synchronised and filtered before edge and condition detection.
`ifndef TSR_REGS_VH
`define TSR_REGS_VH
`define TSR_ADDR_HI 4'h3
`define TSR_PTR_CAP 4'h0
`define TSR_PTR_CFG 4'h1
`define TSR_PTR_UPPER 4'h2
`define TSR_PTR_LOWER 4'h3
`define TSR_PTR_CRIT 4'h4
`define TSR_PTR_TEMP 4'h5
`define TSR_PTR_MAKER 4'h6
`define TSR_PTR_DEVID 4'h7
`define TSR_PTR_EXTID 4'h8
`define TSR_PTR_RES 4'h9
`define TSR_PTR_LAST 4'h9
`define TSR_CAP_RESET 16'h00EF
`define TSR_CFG_RESET 16'h0000
`define TSR_LIMIT_RESET 16'h0000
`define TSR_RES_RESET 16'h0003
`define TSR_CFG_MASK 16'h07FF
`define TSR_LIMIT_MASK 16'h1FFC
`define TSR_RES_MASK 16'h0003
`define TSR_TEMP_MASK 16'h1FFF
`define TSR_TEMP_SIGN 12
`define TSR_CLK_HZ 25000000
`define TSR_TIMEOUT_MS 20
`define TSR_FILT_LEN 3
`endif

//--- rtl/tsr_i2c_slave.v
`timescale 1ns/1ns
`include "tsr_regs.vh"
module tsr_i2c_slave #(
    parameter [31:0] TIMEOUT_CYCLES = (`TSR_CLK_HZ / 1000) * `TSR_TIMEOUT_MS,
    parameter [15:0] MAKER_ID = 16'h0A5A,
    parameter [15:0] DEVICE_ID = 16'h1234,
    parameter [15:0] EXT_ID = 16'h5678
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_n_o,
    input wire addr_select_0_i,
    input wire addr_select_1_i,
    input wire addr_select_2_i,
    input wire [15:0] conv_data_i,
    input wire conv_done_i,
    output reg alert_o,
    output reg alert_oe_n_o,
    output reg [3:0] pointer_o,
    output reg busy_o
);
    // Arbitrary identity values above
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WBYTE = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RBYTE = 3'h5;
    localparam ST_RACK = 3'h6;

    reg scl_m, scl_s, sda_m, sda_s;
    reg [`TSR_FILT_LEN-1:0] scl_h, sda_h;
    reg scl_f, sda_f, scl_p, sda_p;
    reg [2:0] as0, as1;
    reg [6:0] my_addr;
    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg [1:0] wcount;
    reg [7:0] msb_hold;
    reg rd_lsb;
    reg [15:0] rdata;
    reg [31:0] tocnt;
    reg [15:0] configuration, upper_limit, lower_limit, critical_limit;
    reg [15:0] ambient_temperature, conversion_resolution;
    reg do_ack;

    wire scl_rise = scl_f & ~scl_p;
    wire scl_fall = ~scl_f & scl_p;
    wire start_c = scl_f & scl_p & sda_p & ~sda_f; // RULE6
    wire stop_c = scl_f & scl_p & ~sda_p & sda_f; // RULE6
    wire timeout = (tocnt >= TIMEOUT_CYCLES); // RULE13 RULE21

    // Two-flop sync, then history filter that changes only when all samples agree
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            scl_h <= {`TSR_FILT_LEN{1'b1}};
            sda_h <= {`TSR_FILT_LEN{1'b1}};
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            as0 <= 3'h0;
            as1 <= 3'h0;
            my_addr <= 7'h00;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
            scl_h <= {scl_h[`TSR_FILT_LEN-2:0], scl_s};
            sda_h <= {sda_h[`TSR_FILT_LEN-2:0], sda_s};
            if (&scl_h)
                scl_f <= 1'b1;
            else if (~|scl_h)
                scl_f <= 1'b0; // RULE22
            if (&sda_h)
                sda_f <= 1'b1;
            else if (~|sda_h)
                sda_f <= 1'b0; // RULE22
            scl_p <= scl_f;
            sda_p <= sda_f;
            as0 <= {addr_select_2_i, addr_select_1_i, addr_select_0_i};
            as1 <= as0;
            my_addr <= {`TSR_ADDR_HI, as1}; // RULE8
        end
    end

    // Read mux: one register per access
    always @* begin
        case (pointer_o) // RULE4 RULE18
            `TSR_PTR_CAP: rdata = `TSR_CAP_RESET;
            `TSR_PTR_CFG: rdata = configuration;
            `TSR_PTR_UPPER: rdata = upper_limit;
            `TSR_PTR_LOWER: rdata = lower_limit;
            `TSR_PTR_CRIT: rdata = critical_limit;
            `TSR_PTR_TEMP: rdata = ambient_temperature;
            `TSR_PTR_MAKER: rdata = MAKER_ID;
            `TSR_PTR_DEVID: rdata = DEVICE_ID;
            `TSR_PTR_EXTID: rdata = EXT_ID;
            `TSR_PTR_RES: rdata = conversion_resolution;
            default: rdata = 16'h0000;
        endcase
    end

    // Serial state machine
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            wcount <= 2'h0;
            msb_hold <= 8'h00;
            rd_lsb <= 1'b0;
            do_ack <= 1'b0;
            sda_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
            tocnt <= 32'h0;
            busy_o <= 1'b0;
            pointer_o <= 4'h0; // RULE16
            configuration <= `TSR_CFG_RESET;
            upper_limit <= `TSR_LIMIT_RESET;
            lower_limit <= `TSR_LIMIT_RESET;
            critical_limit <= `TSR_LIMIT_RESET;
            conversion_resolution <= `TSR_RES_RESET;
        end else begin
            if (scl_rise || scl_fall || state == ST_IDLE)
                tocnt <= 32'h0;
            else if (!timeout)
                tocnt <= tocnt + 32'h1;
            if (start_c) begin
                state <= ST_ADDR; // RULE1 RULE7
                bitcnt <= 4'h0;
                sda_oe_n_o <= 1'b1;
                busy_o <= 1'b1;
                wcount <= 2'h0;
            end else if (stop_c || timeout) begin
                state <= ST_IDLE; // RULE7 RULE13
                sda_oe_n_o <= 1'b1;
                busy_o <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    ST_ADDR, ST_WBYTE: begin
                        shreg <= {shreg[6:0], sda_f};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    ST_RACK: begin
                        if (sda_f)
                            state <= ST_IDLE; // RULE12
                        else begin
                            state <= ST_RBYTE;
                            rd_lsb <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (bitcnt == 4'h8) begin
                            if (shreg[7:1] == my_addr) begin // RULE9
                                state <= ST_AACK;
                                sda_o <= 1'b0;
                                sda_oe_n_o <= 1'b0;
                                do_ack <= shreg[0]; // RULE10
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        bitcnt <= 4'h0;
                        rd_lsb <= 1'b0;
                        if (do_ack) begin
                            state <= ST_RBYTE;
                            sda_o <= rdata[15];
                            sda_oe_n_o <= 1'b0;
                            shreg <= rdata[14:7];
                            bitcnt <= 4'h1;
                        end else begin
                            state <= ST_WBYTE;
                            sda_oe_n_o <= 1'b1;
                        end
                    end
                    ST_WBYTE: begin
                        if (bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (wcount == 2'h0 && shreg[3:0] > `TSR_PTR_LAST) begin
                                state <= ST_IDLE; // RULE19
                            end else begin
                                state <= ST_WACK;
                                sda_o <= 1'b0; // RULE2
                                sda_oe_n_o <= 1'b0;
                                if (wcount == 2'h0)
                                    pointer_o <= shreg[3:0]; // RULE5 RULE16 RULE17
                                else if (wcount == 2'h1)
                                    msb_hold <= shreg;
                                else begin
                                    case (pointer_o) // RULE4 RULE15
                                        `TSR_PTR_CFG: configuration <= {msb_hold, shreg} & `TSR_CFG_MASK;
                                        `TSR_PTR_UPPER: upper_limit <= {msb_hold, shreg} & `TSR_LIMIT_MASK;
                                        `TSR_PTR_LOWER: lower_limit <= {msb_hold, shreg} & `TSR_LIMIT_MASK;
                                        `TSR_PTR_CRIT: critical_limit <= {msb_hold, shreg} & `TSR_LIMIT_MASK;
                                        `TSR_PTR_RES: conversion_resolution <= {8'h00, shreg} & `TSR_RES_MASK;
                                        default: ;
                                    endcase
                                end
                                if (wcount != 2'h2)
                                    wcount <= wcount + 2'h1;
                            end
                        end
                    end
                    ST_WACK: begin
                        state <= ST_WBYTE;
                        sda_oe_n_o <= 1'b1;
                    end
                    ST_RBYTE: begin
                        if (bitcnt == 4'h8) begin
                            state <= ST_RACK;
                            sda_oe_n_o <= 1'b1; // RULE12
                            bitcnt <= 4'h0;
                        end else if (bitcnt == 4'h0) begin
                            sda_o <= rdata[7];
                            sda_oe_n_o <= 1'b0;
                            shreg <= {rdata[6:0], 1'b0};
                            bitcnt <= 4'h1;
                        end else begin
                            sda_o <= shreg[7];
                            sda_oe_n_o <= 1'b0;
                            shreg <= {shreg[6:0], 1'b0};
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Temperature load and window alert
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ambient_temperature <= 16'h0000;
            alert_o <= 1'b0;
            alert_oe_n_o <= 1'b1;
        end else begin
            if (conv_done_i) begin
                ambient_temperature <= conv_data_i & `TSR_TEMP_MASK; // RULE14
            end
            alert_o <= 1'b0;
            alert_oe_n_o <= !(($signed(ambient_temperature[`TSR_TEMP_SIGN:0]) >
                              $signed(upper_limit[`TSR_TEMP_SIGN:0])) ||
                             ($signed(ambient_temperature[`TSR_TEMP_SIGN:0]) <
                              $signed(lower_limit[`TSR_TEMP_SIGN:0]))); // RULE15
        end
    end
endmodule

//--- sim/tsr_i2c_slave_properties.sv
`timescale 1ns/1ns
module tsr_i2c_slave_properties #(
    parameter [31:0] TIMEOUT_CYCLES = 200
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    input wire alert_o,
    input wire alert_oe_n_o,
    input wire [3:0] pointer_o,
    input wire busy_o
);
    reg scl_prev;
    reg sda_prev;
    reg [15:0] still_cnt;
    // Cycles with both bus lines unchanged
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            still_cnt <= 16'h0000;
        end else begin
            scl_prev <= scl_i;
            sda_prev <= sda_i;
            if (scl_i != scl_prev || sda_i != sda_prev) still_cnt <= 16'h0000;
            else if (still_cnt != 16'hFFFF) still_cnt <= still_cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_reset_values: assert property (disable iff (1'b0) rst_i |-> sda_oe_n_o && alert_oe_n_o
        && pointer_o == 4'h0 && !busy_o) else $error("outputs not at reset values");
    a_idle_released: assert property (!busy_o && $past(!busy_o) |-> sda_oe_n_o)
        else $error("SDA driven while idle");
    a_pointer_update: assert property ($changed(pointer_o) |-> busy_o && pointer_o <= 4'h9)
        else $error("pointer changed badly");
    a_drive_scl_low: assert property ($fell(sda_oe_n_o) |-> busy_o && !scl_i)
        else $error("SDA drive began with SCL high");
    a_bus_timeout: assert property (still_cnt > TIMEOUT_CYCLES + 32 |-> !busy_o)
        else $error("no reset after bus timeout");
    a_start_seen: assert property ($fell(sda_i) && scl_i && $past(scl_i) |-> ##[2:12] busy_o)
        else $error("START not seen");
    a_stop_seen: assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> ##[2:12] !busy_o)
        else $error("STOP not seen");
    a_alert_drain: assert property (!alert_oe_n_o |-> !alert_o)
        else $error("alert pin driven high");
endmodule

//--- sim/tsr_host_model.sv
`timescale 1ns/1ns
module tsr_host_model (
    input wire core_clk_i,
    input wire sda_i,
    output reg scl_o = 1'b1,
    output reg sda_low_o = 1'b0
);
    // One bus phase of 12 core cycles; SCL stands still between frames
    task step(input c, input l);
        begin
            scl_o = c;
            sda_low_o = l;
            repeat (12) @(posedge core_clk_i);
            #2;
        end
    endtask
    task start;
        begin
            step(1'b0, sda_low_o);
            step(1'b0, 1'b0);
            step(1'b1, 1'b0);
            step(1'b1, 1'b1);
            step(1'b0, 1'b1);
        end
    endtask
    task stop;
        begin
            step(1'b0, sda_low_o);
            step(1'b0, 1'b1);
            step(1'b1, 1'b1);
            step(1'b1, 1'b0);
        end
    endtask
    task send_bit(input b, output r);
        begin
            step(1'b0, sda_low_o);
            step(1'b0, !b);
            step(1'b1, !b);
            r = sda_i;
        end
    endtask
    // Ninth clock carries the acknowledge either way
    task xfer(input [7:0] d, input ak, output [7:0] q, output ok);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) send_bit(d[i], q[i]);
            send_bit(ak, r);
            ok = !r;
        end
    endtask
endmodule

//--- sim/tsr_i2c_slave_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tsr_i2c_slave_bench;
    reg core_clk_i = 1'b0;
    reg rst_i = 1'b0;
    reg addr_select_0_i = 1'b1;
    reg addr_select_1_i = 1'b0;
    reg addr_select_2_i = 1'b1;
    reg [15:0] conv_data_i = 16'h0000;
    reg conv_done_i = 1'b0;
    wire scl, host_low, sda_o, sda_oe_n_o, alert_o, alert_oe_n_o, busy_o;
    wire [3:0] pointer_o;
    // Pull-up: low when either party drives low
    wire sda = !(host_low || (!sda_oe_n_o && !sda_o));
    integer fail_count = 0;
    integer check_count = 0;
    integer cycles = 0;
    integer i;
    reg [7:0] q;
    reg a1, a2, a3;
    reg [15:0] rd;
    reg [3:0] pt [0:4];
    reg [15:0] ex [0:4];
    initial forever #20 core_clk_i = !core_clk_i;
    tsr_host_model host_u (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    // Identity values arbitrary
    tsr_i2c_slave #(.TIMEOUT_CYCLES(200), .MAKER_ID(16'h1111), .DEVICE_ID(16'h2222), .EXT_ID(16'h3333)) dut_u (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .addr_select_0_i(addr_select_0_i), .addr_select_1_i(addr_select_1_i), .addr_select_2_i(addr_select_2_i),
        .conv_data_i(conv_data_i),
        .conv_done_i(conv_done_i), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o), .pointer_o(pointer_o),
        .busy_o(busy_o));
    task wr_ptr(input [7:0] p);
        begin
            host_u.start;
            host_u.xfer(8'h3A, 1'b1, q, a1);
            host_u.xfer(p, 1'b1, q, a2);
        end
    endtask
    task wr_reg(input [3:0] p, input [15:0] d);
        begin
            wr_ptr({4'h0, p});
            host_u.xfer(d[15:8], 1'b1, q, a3);
            host_u.xfer(d[7:0], 1'b1, q, a3);
            host_u.stop;
            `CHK({a1, a2, a3}, 3'b111)
        end
    endtask
    task rd_chk(input [15:0] e);
        begin
            host_u.start;
            host_u.xfer(8'h3B, 1'b1, q, a1);
            host_u.xfer(8'hFF, 1'b0, rd[15:8], a2);
            host_u.xfer(8'hFF, 1'b1, rd[7:0], a2);
            `CHK(sda_oe_n_o, 1'b1)
            host_u.stop;
            `CHK({a1, rd}, {1'b1, e})
        end
    endtask
    task conv(input [15:0] d);
        begin
            conv_data_i = d;
            conv_done_i = 1'b1;
            @(posedge core_clk_i);
            #2 conv_done_i = 1'b0;
            repeat (4) @(posedge core_clk_i);
        end
    endtask
    task t_map;
        begin
            `CHK(pointer_o, 4'h0)
            rd_chk(16'h00EF);
            pt = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h9};
            ex = '{16'h00EF, 16'h1111, 16'h2222, 16'h3333, 16'h0003};
            for (i = 0; i < 5; i = i + 1) begin
                wr_ptr({4'h0, pt[i]});
                host_u.stop;
                rd_chk(ex[i]);
            end
            $display("t_map done");
        end
    endtask
    task t_alert;
        begin
            wr_reg(4'h2, 16'h0100);
            conv(16'hE190);
            `CHK(alert_oe_n_o, 1'b0)
            wr_reg(4'h5, 16'hFFFF);
            rd_chk(16'h0190);
            `CHK(pointer_o, 4'h5)
            conv(16'h0050);
            `CHK(alert_oe_n_o, 1'b1)
            wr_reg(4'h3, 16'h0080);
            rd_chk(16'h0080);
            `CHK(alert_oe_n_o, 1'b0)
            $display("t_alert done");
        end
    endtask
    task t_refuse;
        begin
            host_u.start;
            host_u.xfer(8'h38, 1'b1, q, a1);
            host_u.stop;
            `CHK(a1, 1'b0)
            wr_ptr(8'h0A);
            host_u.stop;
            `CHK({a2, pointer_o}, 5'h03)
            host_u.start;
            for (i = 0; i < 4; i = i + 1) host_u.send_bit(1'b0, a1);
            host_u.stop;
            `CHK({busy_o, sda_oe_n_o}, 2'b01)
            $display("t_refuse done");
        end
    endtask
    task t_timeout;
        begin
            wr_ptr(8'h02);
            repeat (300) @(posedge core_clk_i);
            `CHK({busy_o, sda_oe_n_o}, 2'b01)
            rd_chk(16'h0100);
            $display("t_timeout done");
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    always @(posedge core_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 90000) begin
            fail_count++;
            end_of_test;
        end
    end
    initial begin
        #1 rst_i = 1'b1;
        repeat (20) @(posedge core_clk_i);
        #2 rst_i = 1'b0;
        repeat (10) @(posedge core_clk_i);
        #2;
        t_map;
        t_alert;
        t_refuse;
        t_timeout;
        end_of_test;
    end
endmodule
bind tsr_i2c_slave tsr_i2c_slave_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props_u (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .alert_o(alert_o),
    .alert_oe_n_o(alert_oe_n_o), .pointer_o(pointer_o), .busy_o(busy_o));
